// ===== hw/i2c_master_pkg.sv
// How it works
// [RL1] NAK with bytes left raises idle at once
// [RL2] Master disable releases both lines immediately
// [RL3] Software waits two clock periods before disabling
// [RL4] Alert input is sampled active high
// [RL5] System inverts alert; unusable with shared pins
// [RL6] Alert status flag reads set after reset
// [RL7] Software clears alert flag before first transfer
package i2c_master_pkg;

  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] CMD_OFS     = 8'h04;
  localparam logic [7:0] TXDATA_OFS  = 8'h08;
  localparam logic [7:0] RXDATA_OFS  = 8'h0C;
  localparam logic [7:0] STATUS_OFS  = 8'h10;
  localparam logic [7:0] CLEAR_OFS   = 8'h14;
  localparam logic [7:0] DIVIDER_OFS = 8'h18;

  localparam int CTRL_ENABLE_BIT  = 0;
  localparam int CTRL_DISABLE_BIT = 1;

  localparam int CMD_ADDR_LSB  = 0;
  localparam int CMD_READ_BIT  = 7;
  localparam int CMD_COUNT_LSB = 8;

  localparam int ST_IDLE     = 0;
  localparam int ST_RX_FULL  = 1;
  localparam int ST_TX_EMPTY = 2;
  localparam int ST_NAK      = 3;
  localparam int ST_ALERT    = 4;
  localparam int ST_ENABLED  = 5;

  localparam logic IDLE_RESET  = 1'b1;
  localparam logic ALERT_RESET = 1'b1;

  localparam int CLK_PERIOD_NS  = 4;
  localparam int SCL_PERIOD_NS  = 10000;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [15:0] DIV_RESET = 16'(QUARTER_CYCLES);

  typedef enum logic [1:0] {
    OP_START,
    OP_WRITE,
    OP_READ,
    OP_STOP
  } op_t;

endpackage

// ===== hw/bit_engine_if.sv
interface bit_engine_if;
  logic                go;
  i2c_master_pkg::op_t op;
  logic [7:0]          tx_byte;
  logic                nak_out;
  logic                abort;
  logic [15:0]         quarter;
  logic                ready;
  logic                done;
  logic [7:0]          rx_byte;
  logic                nak;

  modport ctrl (
    output go, op, tx_byte, nak_out, abort, quarter,
    input  ready, done, rx_byte, nak
  );
  modport engine (
    input  go, op, tx_byte, nak_out, abort, quarter,
    output ready, done, rx_byte, nak
  );
endinterface

// ===== hw/i2c_bit_engine.sv
module i2c_bit_engine (
  input  wire logic    clk,
  input  wire logic    reset,
  bit_engine_if.engine bus,
  input  wire logic    scl_in,
  input  wire logic    sda_in,
  output logic         scl_oe,
  output logic         sda_oe
);
  typedef enum logic {E_IDLE, E_RUN} eng_state_t;

  eng_state_t          state;
  i2c_master_pkg::op_t op;
  logic                scl_meta;
  logic                scl_sync;
  logic                sda_meta;
  logic                sda_sync;
  logic [15:0]         tick;
  logic [1:0]          quarter;
  logic [3:0]          bitn;
  logic [8:0]          shift;
  logic [7:0]          rx;
  logic                nak;
  logic                done;
  logic                scl_low;
  logic                sda_low;

  // The slave may hold the clock low; the rising quarter waits for it
  wire tick_end = tick == 16'h0000;
  wire stretch  = quarter == 2'h1 && !scl_sync;
  wire step     = state == E_RUN && tick_end && !stretch;
  wire byte_op  = op == i2c_master_pkg::OP_WRITE ||
                  op == i2c_master_pkg::OP_READ;
  wire last_bit = !byte_op || bitn == 4'h8;
  wire op_end   = step && quarter == 2'h3 && last_bit;
  wire launch   = state == E_IDLE && bus.go && !bus.abort;
  wire is_start = op == i2c_master_pkg::OP_START;
  wire is_stop  = op == i2c_master_pkg::OP_STOP;

  assign bus.ready   = state == E_IDLE;
  assign bus.done    = done;
  assign bus.rx_byte = rx;
  assign bus.nak     = nak;
  assign scl_oe      = scl_low;
  assign sda_oe      = sda_low;

  always_ff @(posedge clk) begin
    scl_meta <= scl_in;
    scl_sync <= scl_meta;
    sda_meta <= sda_in;
    sda_sync <= sda_meta;
  end

  always_ff @(posedge clk) begin
    if (reset || bus.abort) begin
      state <= E_IDLE;
      done  <= 1'b0;
    end else begin
      done <= op_end;
      if (launch) begin
        state <= E_RUN;
      end else if (op_end) begin
        state <= E_IDLE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tick    <= 16'h0000;
      quarter <= 2'h0;
      bitn    <= 4'h0;
      op      <= i2c_master_pkg::OP_START;
      shift   <= 9'h1FF;
    end else if (launch) begin
      tick    <= bus.quarter - 16'h0001;
      quarter <= 2'h0;
      bitn    <= 4'h0;
      op      <= bus.op;
      shift   <= bus.op == i2c_master_pkg::OP_READ ?
                 {8'hFF, bus.nak_out} : {bus.tx_byte, 1'b1};
    end else if (step) begin
      tick    <= bus.quarter - 16'h0001;
      quarter <= quarter + 2'h1;
      if (quarter == 2'h3) begin
        bitn  <= bitn + 4'h1;
        shift <= {shift[7:0], 1'b1};
      end
    end else if (!tick_end) begin
      tick <= tick - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx  <= 8'h00;
      nak <= 1'b0;
    end else if (step && quarter == 2'h1 && byte_op) begin
      if (bitn == 4'h8) begin
        nak <= sda_sync;
      end else begin
        rx <= {rx[6:0], sda_sync};
      end
    end
  end

  // Released lines float high; abort lets go of both at once
  always_ff @(posedge clk) begin
    if (reset || bus.abort) begin
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (launch) begin
      unique case (bus.op)
        i2c_master_pkg::OP_START: sda_low <= 1'b0;
        i2c_master_pkg::OP_STOP:  sda_low <= 1'b1;
        // The slave drives the first bit of a read byte
        i2c_master_pkg::OP_READ:  sda_low <= 1'b0;
        i2c_master_pkg::OP_WRITE: sda_low <= !bus.tx_byte[7];
      endcase
    end else if (step) begin
      unique case (quarter)
        2'h0: scl_low <= 1'b0;
        2'h1: if (is_start) begin
          sda_low <= 1'b1;
        end
        2'h2: if (is_stop) begin
          sda_low <= 1'b0;
        end else begin
          scl_low <= 1'b1;
        end
        2'h3: if (!last_bit) begin
          sda_low <= !shift[7];
        end
      endcase
    end
  end
endmodule

// ===== hw/i2c_master.sv
// Implementation choices: the register addresses and the strobed register port.
module i2c_master #(
  parameter logic [15:0] QUARTER_RESET = i2c_master_pkg::DIV_RESET
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        alert_input
);
  typedef enum logic [2:0] {
    M_IDLE,
    M_START,
    M_ADDR,
    M_DATA,
    M_STOP
  } mstate_t;

  mstate_t     state;
  mstate_t     next_state;
  logic        enabled;
  logic        idle;
  logic        nak_flag;
  logic        alert_flag;
  logic        alert_meta;
  logic        alert_sync;
  logic [7:0]  tx_data;
  logic        tx_full;
  logic [7:0]  rx_data;
  logic        rx_full;
  logic [6:0]  slave_addr;
  logic        read_dir;
  logic [7:0]  count;
  logic [15:0] quarter;
  logic        pending;
  logic [31:0] status_word;
  logic [31:0] read_word;

  bit_engine_if eng_bus ();

  i2c_bit_engine u_engine (
    .clk    (clk),
    .reset  (reset),
    .bus    (eng_bus.engine),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .scl_oe (scl_oe),
    .sda_oe (sda_oe)
  );

  // Open drain: a driven line is always pulled low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  wire wr_ctrl  = wr && addr == i2c_master_pkg::CTRL_OFS;
  wire wr_cmd   = wr && addr == i2c_master_pkg::CMD_OFS;
  wire wr_tx    = wr && addr == i2c_master_pkg::TXDATA_OFS;
  wire wr_clear = wr && addr == i2c_master_pkg::CLEAR_OFS;
  wire wr_div   = wr && addr == i2c_master_pkg::DIVIDER_OFS;
  wire rd_rx    = rd && addr == i2c_master_pkg::RXDATA_OFS;

  wire disable_req = wr_ctrl && wdata[i2c_master_pkg::CTRL_DISABLE_BIT];
  wire enable_req  = wr_ctrl && wdata[i2c_master_pkg::CTRL_ENABLE_BIT] &&
                     !disable_req;
  wire start_req   = wr_cmd && enabled && state == M_IDLE;

  wire eng_done  = eng_bus.done;
  wire in_addr   = state == M_ADDR;
  wire in_write  = state == M_DATA && !read_dir;
  wire in_read   = state == M_DATA && read_dir;
  wire last_byte = count == 8'h01;
  wire got_nak   = eng_done && eng_bus.nak && (in_addr || in_write);

  // The early idle is not a bus-free indication: a stop still follows
  wire early_idle = got_nak && (in_addr ? count != 8'h00 : !last_byte);
  wire stop_done  = state == M_STOP && eng_done;
  wire data_ok    = state != M_DATA || (read_dir ? !rx_full : tx_full);
  wire issue      = !pending && eng_bus.ready && state != M_IDLE &&
                    data_ok && !disable_req;
  wire alert_set  = alert_sync && enabled;
  wire clr_nak    = wr_clear && wdata[i2c_master_pkg::ST_NAK];
  wire clr_alert  = wr_clear && wdata[i2c_master_pkg::ST_ALERT];
  wire rx_set     = in_read && eng_done;
  wire tx_take    = issue && in_write;

  assign eng_bus.go      = issue;
  assign eng_bus.abort   = disable_req; // see [RL2]
  assign eng_bus.quarter = quarter;
  assign eng_bus.nak_out = last_byte;
  assign eng_bus.tx_byte = in_addr ? {slave_addr, read_dir} : tx_data;
  assign eng_bus.op      = state == M_START ? i2c_master_pkg::OP_START :
                           state == M_STOP  ? i2c_master_pkg::OP_STOP  :
                           in_read          ? i2c_master_pkg::OP_READ  :
                                              i2c_master_pkg::OP_WRITE;

  always_comb begin
    next_state = state;
    if (disable_req) begin
      next_state = M_IDLE; // see [RL2]
    end else begin
      unique case (state)
        M_IDLE: if (start_req) begin
          next_state = M_START;
        end
        M_START: if (eng_done) begin
          next_state = M_ADDR;
        end
        M_ADDR: if (eng_done) begin
          next_state = eng_bus.nak || count == 8'h00 ? M_STOP : M_DATA;
        end
        M_DATA: if (eng_done) begin
          next_state = got_nak || last_byte ? M_STOP : M_DATA;
        end
        M_STOP: if (stop_done) begin
          next_state = M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state   <= M_IDLE;
      pending <= 1'b0;
    end else begin
      state <= next_state;
      if (disable_req || eng_done) begin
        pending <= 1'b0;
      end else if (issue) begin
        pending <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      enabled <= 1'b0;
    end else if (disable_req) begin
      enabled <= 1'b0;
    end else if (enable_req) begin
      enabled <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      idle <= i2c_master_pkg::IDLE_RESET;
    end else if (disable_req || early_idle || stop_done) begin
      idle <= 1'b1; // see [RL1]
    end else if (start_req) begin
      idle <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      slave_addr <= 7'h00;
      read_dir   <= 1'b0;
      count      <= 8'h00;
    end else if (start_req) begin
      slave_addr <= wdata[i2c_master_pkg::CMD_ADDR_LSB +: 7];
      read_dir   <= wdata[i2c_master_pkg::CMD_READ_BIT];
      count      <= wdata[i2c_master_pkg::CMD_COUNT_LSB +: 8];
    end else if (state == M_DATA && eng_done) begin
      count <= count - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      quarter <= QUARTER_RESET;
    end else if (wr_div) begin
      quarter <= wdata[15:0] == 16'h0000 ? 16'h0001 : wdata[15:0];
    end
  end

  // Only the second stage is read; the first may be metastable
  always_ff @(posedge clk) begin
    alert_meta <= alert_input;
    alert_sync <= alert_meta;
  end

  // Hardware sets win over software clears in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      alert_flag <= i2c_master_pkg::ALERT_RESET; // see [RL6]
    end else if (alert_set) begin
      alert_flag <= 1'b1; // see [RL4]
    end else if (clr_alert) begin
      alert_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      nak_flag <= 1'b0;
    end else if (got_nak) begin
      nak_flag <= 1'b1;
    end else if (clr_nak) begin
      nak_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_data <= 8'h00;
      tx_full <= 1'b0;
    end else begin
      if (wr_tx) begin
        tx_data <= wdata[7:0];
      end
      if (wr_tx) begin
        tx_full <= 1'b1;
      end else if (tx_take) begin
        tx_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_data <= 8'h00;
      rx_full <= 1'b0;
    end else if (rx_set) begin
      rx_data <= eng_bus.rx_byte;
      rx_full <= 1'b1;
    end else if (rd_rx) begin
      rx_full <= 1'b0;
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[i2c_master_pkg::ST_IDLE]     = idle;
    status_word[i2c_master_pkg::ST_RX_FULL]  = rx_full;
    status_word[i2c_master_pkg::ST_TX_EMPTY] = !tx_full;
    status_word[i2c_master_pkg::ST_NAK]      = nak_flag;
    status_word[i2c_master_pkg::ST_ALERT]    = alert_flag;
    status_word[i2c_master_pkg::ST_ENABLED]  = enabled;
  end

  always_comb begin
    unique case (addr)
      i2c_master_pkg::CTRL_OFS:    read_word = {31'h00000000, enabled};
      i2c_master_pkg::CMD_OFS:     read_word = {16'h0000, count,
                                                read_dir, slave_addr};
      i2c_master_pkg::TXDATA_OFS:  read_word = {24'h000000, tx_data};
      i2c_master_pkg::RXDATA_OFS:  read_word = {24'h000000, rx_data};
      i2c_master_pkg::STATUS_OFS:  read_word = status_word;
      i2c_master_pkg::DIVIDER_OFS: read_word = {16'h0000, quarter};
      default:                     read_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? read_word : 32'h00000000;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_nak_early_idle: assert property ( // see [RL1]
    early_idle |=> idle && state == M_STOP && pending == 1'b0)
    else $error("idle not raised at once after nak");

  a_idle_before_stop: assert property ( // see [RL1]
    early_idle ##1 (state == M_STOP)[*2] |-> idle && !eng_bus.ready)
    else $error("idle dropped while stop still pending");

  a_disable_release: assert property ( // see [RL2]
    disable_req |=> !scl_oe && !sda_oe && state == M_IDLE && !enabled)
    else $error("lines not released after master disable");

  a_disable_no_stop: assert property ( // see [RL2]
    disable_req |=> (!scl_oe && !sda_oe && !enable_req) [*1]
      ##0 !pending)
    else $error("engine still active after disable");

  a_alert_high: assert property ( // see [RL4]
    alert_sync && enabled |=> alert_flag)
    else $error("alert flag not set on high alert input");

  a_alert_sync_path: assert property ( // see [RL4]
    $rose(alert_input) && enabled ##2 enabled && !clr_alert
      |=> alert_flag)
    else $error("high alert input not seen after two stages");

  a_alert_reset: assert property ( // see [RL6]
    $past(reset) |-> alert_flag)
    else $error("alert flag not set after reset");

  a_stop_to_idle: assert property (
    stop_done && !disable_req |=> idle && state == M_IDLE)
    else $error("idle not raised after stop");

  c_early_idle: cover property (early_idle ##[1:1000] stop_done);
  c_disable_busy: cover property (disable_req && state != M_IDLE);
  c_read_done: cover property (rx_set && last_byte);
  c_write_done: cover property (stop_done && !nak_flag && !read_dir);
endmodule

// ===== tb/i2c_slave_model.sv
module i2c_slave_model (
  input  wire logic       clk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [3:0] nak_byte,
  input  wire logic [7:0] stretch,
  output logic            scl_oe,
  output logic            sda_oe,
  output logic            active,
  output logic [3:0]      n_bytes,
  output logic [7:0]      first_byte,
  output logic [7:0]      last_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       scl_q;
  logic       sda_q;
  logic       acking;
  logic [3:0] bitc;
  logic [7:0] sh;
  logic [7:0] hold;
  logic       rd_mode;
  logic       mnak;
  logic [7:0] tsh;
  // Bytes sent back on a read: C0, C1, ...
  wire  [7:0] txv    = 8'hC0 + {4'h0, n_bytes};
  wire        rd_now = n_bytes == 4'h0 ? sh[0] : rd_mode;

  initial begin
    {scl_oe, sda_oe, active, acking, scl_q, sda_q} = '0;
    {n_bytes, bitc, sh, hold, first_byte, last_byte} = '0;
    {rd_mode, mnak, tsh} = '0;
  end

  // Samples the wires like a real slave; lines it lets go float to pull-up
  always @(posedge clk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end else begin
      scl_oe <= 1'b0;
    end
    if (scl && scl_q && sda_q && !sda) begin
      active  <= 1'b1;
      bitc    <= 4'h0;
      n_bytes <= 4'h0;
      acking  <= 1'b0;
      rd_mode <= 1'b0;
    end else if (scl && scl_q && !sda_q && sda) begin
      active <= 1'b0;
    end else if (active && scl && !scl_q && bitc < 4'h8) begin
      sh   <= {sh[6:0], sda};
      bitc <= bitc + 4'h1;
    end else if (active && scl && !scl_q) begin
      mnak <= sda;
    end else if (active && !scl && scl_q) begin
      if (acking) begin
        // On a read, go on sending unless the master refused the byte
        sda_oe    <= rd_now && !mnak && !txv[7];
        tsh       <= {txv[6:0], 1'b1};
        rd_mode   <= rd_now;
        acking    <= 1'b0;
        bitc      <= 4'h0;
        n_bytes   <= n_bytes + 4'h1;
        last_byte <= sh;
        if (n_bytes == 4'h0) begin
          first_byte <= sh;
        end
        // Slow answer: hold the clock low after each byte
        scl_oe <= (stretch != 8'h00);
        hold   <= stretch;
      end else if (bitc == 4'h8) begin
        sda_oe <= !rd_mode && (n_bytes != nak_byte);
        acking <= 1'b1;
      end else if (rd_mode && bitc != 4'h0) begin
        sda_oe <= !tsh[7];
        tsh    <= {tsh[6:0], 1'b1};
      end
    end
  end
endmodule

// ===== tb/i2c_master_errata_behaviour_tb_top.sv
module i2c_master_errata_behaviour_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        alert_n = 1'b1;
  logic [3:0]  nak_byte = 4'hF;
  logic [7:0]  stretch = 8'h00;
  logic [31:0] rdata;
  logic        scl_oe, sda_oe, scl_out, sda_out, s_scl_oe, s_sda_oe, s_act;
  logic [3:0]  s_n;
  logic [7:0]  s_first, s_last;
  logic [31:0] d;
  int          n_mismatch = 0;
  int          comparisons = 0;
  // Open-drain wires with pull-up
  wire logic   scl = !scl_oe && !s_scl_oe;
  wire logic   sda = !sda_oe && !s_sda_oe;

  i2c_master dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scl_in(scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .alert_input(!alert_n)  // External inverter
  );
  i2c_slave_model slave (
    .clk(clk), .scl(scl), .sda(sda), .nak_byte(nak_byte),
    .stretch(stretch), .scl_oe(s_scl_oe), .sda_oe(s_sda_oe),
    .active(s_act), .n_bytes(s_n), .first_byte(s_first), .last_byte(s_last)
  );

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000; i++) begin
      rd_reg(i2c_master_pkg::STATUS_OFS, d);
      if (d[i2c_master_pkg::ST_IDLE] === 1'b1) begin
        return;
      end
    end
    chk(32'h0, 32'h1, "idle never seen");
  endtask

  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end

  initial begin
    do_reset();
    // Idle, tx_empty and the spurious alert flag after reset
    rd_reg(i2c_master_pkg::STATUS_OFS, d);
    chk(d, 32'h0000_0015, "status after reset");
    @(posedge clk);
    #1;
    chk(rdata, 32'h0, "rdata after read cycle");
    chk({30'h0, scl_out, sda_out}, 32'h0, "open drain outputs");
    wr_reg(i2c_master_pkg::CLEAR_OFS, 32'h0000_0010);
    rd_reg(i2c_master_pkg::STATUS_OFS, d);
    chk(d, 32'h0000_0005, "alert cleared");
    rd_reg(8'h1C, d);
    chk(d, 32'h0, "unmapped read");
    wr_reg(i2c_master_pkg::DIVIDER_OFS, 32'h0);
    rd_reg(i2c_master_pkg::DIVIDER_OFS, d);
    chk(d, 32'h0000_0001, "divider zero");
    // Ten clocks per quarter gives the 160 ns link clock
    wr_reg(i2c_master_pkg::DIVIDER_OFS, 32'h0000_000A);
    rd_reg(i2c_master_pkg::DIVIDER_OFS, d);
    chk(d, 32'h0000_000A, "divider");
    wr_reg(i2c_master_pkg::CTRL_OFS, 32'h0000_0001);
    // One-byte writes, prompt slave then stretching slave
    for (int i = 0; i < 2; i++) begin
      stretch <= (i == 0) ? 8'h00 : 8'h14;
      wr_reg(i2c_master_pkg::TXDATA_OFS, 32'(8'h5A ^ 8'(i)));
      wr_reg(i2c_master_pkg::CMD_OFS, 32'h0000_012A);
      wait_idle();
      chk(d, 32'h0000_0025, "status after write");
      chk({28'h0, s_n}, 32'h2, "byte count seen");
      chk({24'h0, s_first}, 32'h54, "address byte");
      chk({24'h0, s_last}, 32'(8'h5A ^ 8'(i)), "data byte");
      chk({30'h0, scl, sda}, 32'h3, "bus idle high");
    end
    stretch <= 8'h00;
    // Two-byte read: slave sends C0 then C1, master refuses the last
    wr_reg(i2c_master_pkg::CMD_OFS, 32'h0000_02AA);
    for (int i = 0; i < 2; i++) begin
      d = 32'h0;
      for (int k = 0; k < 1000; k++) begin
        if (d[i2c_master_pkg::ST_RX_FULL] === 1'b1) begin
          break;
        end
        rd_reg(i2c_master_pkg::STATUS_OFS, d);
      end
      rd_reg(i2c_master_pkg::RXDATA_OFS, d);
      chk(d, 32'(8'hC0 + 8'(i)), "read byte");
    end
    wait_idle();
    chk({28'h0, s_n}, 32'h3, "read byte count");
    chk({24'h0, s_last}, 32'h0000_00C1, "last read byte");
    // Early idle on NAK while bytes remain, then a hasty disable
    nak_byte <= 4'h1;
    wr_reg(i2c_master_pkg::TXDATA_OFS, 32'h0000_0033);
    wr_reg(i2c_master_pkg::CMD_OFS, 32'h0000_022A);
    wait_idle();
    chk({31'h0, s_act}, 32'h1, "idle before stop");
    chk({31'h0, d[i2c_master_pkg::ST_NAK]}, 32'h1, "nak flag");
    wr_reg(i2c_master_pkg::CTRL_OFS, 32'h0000_0002);
    chk({30'h0, scl_oe, sda_oe}, 32'h0, "lines released");
    rd_reg(i2c_master_pkg::STATUS_OFS, d);
    chk({31'h0, d[i2c_master_pkg::ST_ENABLED]}, 32'h0, "off");
    wr_reg(i2c_master_pkg::CLEAR_OFS, 32'h0000_0008);
    nak_byte <= 4'hF;
    // Alert input is active high at the pin of the block
    wr_reg(i2c_master_pkg::CTRL_OFS, 32'h0000_0001);
    repeat (8) @(posedge clk);
    wr_reg(i2c_master_pkg::CLEAR_OFS, 32'h0000_0010);
    rd_reg(i2c_master_pkg::STATUS_OFS, d);
    chk({31'h0, d[i2c_master_pkg::ST_ALERT]}, 32'h0, "no alert");
    @(posedge clk);
    alert_n <= 1'b0;
    repeat (5) @(posedge clk);
    rd_reg(i2c_master_pkg::STATUS_OFS, d);
    chk({31'h0, d[i2c_master_pkg::ST_ALERT]}, 32'h1, "alert up");
    @(posedge clk);
    alert_n <= 1'b1;
    repeat (5) @(posedge clk);
    wr_reg(i2c_master_pkg::CLEAR_OFS, 32'h0000_0010);
    rd_reg(i2c_master_pkg::STATUS_OFS, d);
    chk({31'h0, d[i2c_master_pkg::ST_ALERT]}, 32'h0, "alert off");
    // Orderly disable two link periods after idle
    repeat (80) @(posedge clk);
    wr_reg(i2c_master_pkg::CTRL_OFS, 32'h0000_0002);
    rd_reg(i2c_master_pkg::CTRL_OFS, d);
    chk(d, 32'h0, "ctrl disabled");
    // Second reset in mid-run brings the flag back
    do_reset();
    chk({30'h0, scl_oe, sda_oe}, 32'h0, "lines after reset");
    rd_reg(i2c_master_pkg::STATUS_OFS, d);
    chk(d, 32'h0000_0015, "status second reset");
    test_done();
  end
endmodule
